// ### pic_charger_regs.v
// Interrupt, charger status and charger control registers behind the I2C slave
// Operation
// - Supply mask set and applied or removed flag set pulls interrupt pin low.
// - Touch event interrupts only when the touch mask bit is set.
// - Push-button event interrupts only when the push-button mask is set.
// - Touch flag sets on touch, held until interrupt register read clears it.
// - Push-button flag sets on button activation, cleared by register read.
// - Input-applied flag sets on supply appearing, cleared by read.
// - Input-removed flag sets on supply disappearing, cleared by read.
// - Undervoltage lockout reloads all fields with their defaults.
// - Status bit 7 shows thermal regulation reducing charge current.
// - Status bit 6 shows the power-path loop cutting charge current.
// - Status bit 5 shows charging paused for battery temperature.
// - Status bit 4 shows termination current reached and charging stopped.
// - Status bits 2 and 1 show charge and pre-charge timer timeouts.
// - Status bit 0 shows no battery temperature sensor detected.
// - Two-bit field selects 4, 5, 6 or 8 hour safety timer.
// - Timer enable bit gates pre-charge, fast-charge and taper timers.
// - Charger held in reset while reset bit is 1; restart after clearing.
// - Termination-disable bit keeps charger always on when set.
// - Suspend bit freezes safety and pre-charge timers.
// - Enable bit turns charger on or off without resetting algorithm.
// - Registers reached over I2C at fixed address; unlisted reads return zero.
`timescale 1ns/1ps
`default_nettype none
`include "pic_regs.vh"
module pic_charger_regs #(
    parameter ALT_DEFAULTS = 0
) (
    input wire i_clk, // System clock, 100 MHz
    input wire i_rst_n, // Synchronous reset, active low
    input wire i_undervoltage_lockout, // Supply below lockout threshold
    input wire i_scl, // I2C clock pin
    input wire i_sda, // I2C data pin level
    output wire o_sda_o, // I2C data drive value, always low
    output wire o_sda_oe, // I2C data drive enable
    output wire o_int_n_o, // Interrupt pin drive value, always low
    output wire o_int_n_oe, // Interrupt pin pull-down enable
    input wire i_pushbutton_in, // Push-button pin
    input wire i_pb_active_high, // Push-button polarity option
    input wire i_touch_detect, // Touch screen controller touch level
    input wire i_usb_present, // USB supply valid
    input wire i_ac_present, // AC supply valid
    input wire i_thermal_reg, // Die-hot current reduction active
    input wire i_dynamic_power_path_loop, // Power-path loop active
    input wire i_thermal_suspend, // Battery temperature out of range
    input wire i_term_current, // Termination threshold crossed
    input wire i_chg_timeout, // Charge timer expired
    input wire i_prechg_timeout, // Pre-charge timer expired
    input wire i_bat_temp_error, // No temperature sensor found
    output reg [3:0] o_safety_hours, // Selected safety timer length in hours
    output reg o_timers_run, // Pre-charge, fast and taper timers may count
    output reg o_safety_freeze, // Safety and pre-charge timers frozen
    output reg o_sensor_10k, // Thermistor curve select
    output reg o_charger_reset, // Charge algorithm held in reset
    output reg o_term_disable, // Termination suppressed
    output reg o_charger_enable // Charger on
);
    // ****************************************
    // Input synchronisers
    // ****************************************
    wire [10:0] raw_in = {i_scl, i_sda, i_pushbutton_in, i_touch_detect,
        i_usb_present, i_ac_present, i_undervoltage_lockout, i_pb_active_high,
        i_thermal_reg, i_dynamic_power_path_loop, i_thermal_suspend};
    wire [10:0] syn_in;
    wire [3:0] syn_st;

    pic_sync #(.WIDTH(11)) u_sync_a (
        .i_clk(i_clk),
        .i_async(raw_in),
        .o_sync(syn_in)
    );
    pic_sync #(.WIDTH(4)) u_sync_b (
        .i_clk(i_clk),
        .i_async({i_term_current, i_chg_timeout, i_prechg_timeout, i_bat_temp_error}),
        .o_sync(syn_st)
    );

    wire scl_s = syn_in[10];
    wire sda_s = syn_in[9];
    wire pb_s = syn_in[8];
    wire touch_s = syn_in[7];
    wire usb_s = syn_in[6];
    wire ac_s = syn_in[5];
    wire undervoltage_lockout_s = syn_in[4];
    wire pb_pol_s = syn_in[3];

    // ****************************************
    // I2C slave
    // ****************************************
    wire [7:0] addr;
    wire wr_stb;
    wire [7:0] wr_data;
    wire rd_stb;
    reg [7:0] rd_data;

    pic_i2c_slave u_i2c (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n & ~undervoltage_lockout_s),
        .i_scl(scl_s),
        .i_sda(sda_s),
        .o_sda_oe(o_sda_oe),
        .o_addr(addr),
        .o_wr_stb(wr_stb),
        .o_wr_data(wr_data),
        .o_rd_stb(rd_stb),
        .i_rd_data(rd_data)
    );
    assign o_sda_o = 1'b0;

    // ****************************************
    // Event detection
    // ****************************************
    reg touch_d;
    reg pb_act_d;
    reg supply_d;
    reg [2:0] int_mask;
    reg [3:0] events;
    reg [7:0] ctrl;

    wire pb_act = pb_pol_s ? pb_s : ~pb_s;
    wire supply = usb_s | ac_s;
    wire [3:0] ev_set;
    assign ev_set[`PIC_BIT_EV_TOUCH] = touch_s & ~touch_d;
    assign ev_set[`PIC_BIT_EV_PB] = pb_act & ~pb_act_d;
    assign ev_set[`PIC_BIT_EV_APPLIED] = supply & ~supply_d;
    assign ev_set[`PIC_BIT_EV_REMOVED] = ~supply & supply_d;

    wire int_read = rd_stb && addr == `PIC_ADDR_INT;
    wire [2:0] mask_rst = (ALT_DEFAULTS != 0) ? `PIC_INT_MASK_RESET_ALT : `PIC_INT_MASK_RESET;

    // ****************************************
    // Register update
    // ****************************************
    always @(posedge i_clk) begin
        if (!i_rst_n || undervoltage_lockout_s) begin
            // Track levels so a level held across lockout is no new event
            touch_d <= touch_s;
            pb_act_d <= pb_act;
            supply_d <= supply;
            int_mask <= mask_rst;
            events <= 4'h0;
            // Alternate variant also powers up with the charger off
            ctrl <= (ALT_DEFAULTS != 0) ? (`PIC_CTRL_RESET_VAL & 8'hFE) : `PIC_CTRL_RESET_VAL;
        end else begin
            touch_d <= touch_s;
            pb_act_d <= pb_act;
            supply_d <= supply;
            // Set wins over the clearing read
            events <= (int_read ? 4'h0 : events) | ev_set;
            if (wr_stb && addr == `PIC_ADDR_INT) begin
                int_mask <= wr_data[7:5];
            end
            if (wr_stb && addr == `PIC_ADDR_CTRL) begin
                ctrl <= wr_data;
            end
        end
    end

    // ****************************************
    // Interrupt pin
    // ****************************************
    wire irq_supply = int_mask[2] & (events[`PIC_BIT_EV_APPLIED] | events[`PIC_BIT_EV_REMOVED]);
    wire irq_touch = int_mask[1] & events[`PIC_BIT_EV_TOUCH];
    wire irq_pb = int_mask[0] & events[`PIC_BIT_EV_PB];
    assign o_int_n_oe = irq_supply | irq_touch | irq_pb;
    assign o_int_n_o = 1'b0;

    // ****************************************
    // Read mux
    // ****************************************
    wire [7:0] status = {syn_in[2], syn_in[1], syn_in[0], syn_st[3], 1'b0,
        syn_st[2], syn_st[1], syn_st[0]};

    always @* begin
        case (addr)
            `PIC_ADDR_INT: rd_data = {int_mask, 1'b0, events};
            `PIC_ADDR_STAT: rd_data = status;
            `PIC_ADDR_CTRL: rd_data = ctrl;
            default: rd_data = `PIC_BYTE_ZERO;
        endcase
    end

    // ****************************************
    // Charger control outputs
    // ****************************************
    function [3:0] pic_hours;
        input [1:0] sel;
        begin
            case (sel)
                `PIC_TMR_4H: pic_hours = `PIC_HOURS_4;
                `PIC_TMR_5H: pic_hours = `PIC_HOURS_5;
                `PIC_TMR_6H: pic_hours = `PIC_HOURS_6;
                default: pic_hours = `PIC_HOURS_8;
            endcase
        end
    endfunction

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_safety_hours <= `PIC_HOURS_4;
            o_timers_run <= 1'b0;
            o_safety_freeze <= 1'b0;
            o_sensor_10k <= 1'b0;
            o_charger_reset <= 1'b1;
            o_term_disable <= 1'b0;
            o_charger_enable <= 1'b0;
        end else begin
            o_safety_hours <= pic_hours(ctrl[`PIC_CTRL_TIMER_HI:`PIC_CTRL_TIMER_LO]);
            o_timers_run <= ctrl[`PIC_CTRL_TIMER_EN];
            o_safety_freeze <= ctrl[`PIC_CTRL_SUSPEND];
            o_sensor_10k <= ctrl[`PIC_CTRL_SENSOR];
            o_charger_reset <= ctrl[`PIC_CTRL_RESET];
            o_term_disable <= ctrl[`PIC_CTRL_TERM_DIS];
            // Enable alone never resets the algorithm
            o_charger_enable <= ctrl[`PIC_CTRL_ENABLE];
        end
    end
endmodule // pic_charger_regs
`default_nettype wire

// ### pic_charger_regs_properties.sv
// Concurrent checks on the charger register slice ports
`timescale 1ns/1ps
`default_nettype none
module pic_charger_regs_checker (
    input wire logic i_clk, // System clock
    input wire logic i_rst_n, // Sync reset, active low
    input wire logic i_undervoltage_lockout, // Lockout level
    input wire logic i_scl, // I2C clock
    input wire logic o_sda_o, // Data drive value
    input wire logic o_sda_oe, // Data drive enable
    input wire logic o_int_n_o, // Interrupt drive value
    input wire logic o_int_n_oe, // Interrupt pull-down
    input wire logic i_pushbutton_in, // Push-button pin
    input wire logic i_touch_detect, // Touch level
    input wire logic i_usb_present, // USB supply
    input wire logic i_ac_present, // AC supply
    input wire logic [3:0] o_safety_hours, // Timer length
    input wire logic o_timers_run, // Timers enabled
    input wire logic o_safety_freeze, // Timers frozen
    input wire logic o_sensor_10k, // Sensor curve
    input wire logic o_charger_reset, // Charger reset
    input wire logic o_term_disable, // No termination
    input wire logic o_charger_enable // Charger on
);
    logic scl_q;
    logic [3:0] ev_q;
    logic [3:0] bus_quiet;
    logic [3:0] ev_quiet;
    // Saturating spans since bus activity and since a source edge
    always_ff @(posedge i_clk) begin
        scl_q <= i_scl;
        ev_q <= {i_pushbutton_in, i_touch_detect, i_usb_present, i_ac_present};
        if (!i_rst_n || i_undervoltage_lockout || i_scl != scl_q) begin
            bus_quiet <= 4'h0;
        end else if (bus_quiet != 4'hF) begin
            bus_quiet <= bus_quiet + 4'h1;
        end
        if (!i_rst_n || ev_q != {i_pushbutton_in, i_touch_detect, i_usb_present, i_ac_present}) begin
            ev_quiet <= 4'h0;
        end else if (ev_quiet != 4'hF) begin
            ev_quiet <= ev_quiet + 4'h1;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    AST_OPEN_DRAIN: assert property (o_sda_o == 1'b0 && o_int_n_o == 1'b0)
        else $error("Open-drain drive value not low");
    AST_HOURS_CODE: assert property (disable iff (!i_rst_n)
        o_safety_hours inside {4'h4, 4'h5, 4'h6, 4'h8})
        else $error("Safety timer length outside 4, 5, 6, 8");
    AST_RESET_FORM: assert property (!i_rst_n ##1 !i_rst_n |-> !o_sda_oe && !o_int_n_oe
        && o_charger_reset && !o_timers_run) else $error("Outputs not in reset form");
    AST_RESET_DEFAULTS: assert property (disable iff (!i_rst_n) $rose(i_rst_n) |=> ##1
        (o_timers_run && o_sensor_10k && !o_charger_reset && !o_term_disable && !o_safety_freeze))
        else $error("Control defaults missing after reset");
    AST_LOCKOUT_DEFAULTS: assert property (disable iff (!i_rst_n) i_undervoltage_lockout[*6]
        |-> !o_int_n_oe && o_timers_run && !o_charger_reset && o_safety_hours == 4'h4)
        else $error("Defaults missing during lockout");
    AST_INT_RISE_CAUSE: assert property (disable iff (!i_rst_n) $rose(o_int_n_oe)
        |-> ev_quiet < 4'h8 || bus_quiet < 4'h8) else $error("Interrupt rose without cause");
    AST_INT_FALL_CAUSE: assert property (disable iff (!i_rst_n) $fell(o_int_n_oe)
        |-> bus_quiet < 4'h8) else $error("Interrupt released without read or lockout");
    AST_CTRL_WRITE_ONLY: assert property (disable iff (!i_rst_n)
        !$stable({o_safety_hours, o_timers_run, o_safety_freeze, o_sensor_10k, o_charger_reset,
        o_term_disable, o_charger_enable}) |-> bus_quiet < 4'hC)
        else $error("Control output changed without host access");
    AST_SDA_SCL_LOW: assert property (disable iff (!i_rst_n) !$stable(o_sda_oe) |-> !i_scl)
        else $error("Data line changed while clock high");
endmodule // pic_charger_regs_checker
bind pic_charger_regs pic_charger_regs_checker chk_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_undervoltage_lockout(i_undervoltage_lockout), .i_scl(i_scl), .o_sda_o(o_sda_o),
    .o_sda_oe(o_sda_oe), .o_int_n_o(o_int_n_o), .o_int_n_oe(o_int_n_oe),
    .i_pushbutton_in(i_pushbutton_in), .i_touch_detect(i_touch_detect),
    .i_usb_present(i_usb_present), .i_ac_present(i_ac_present), .o_safety_hours(o_safety_hours),
    .o_timers_run(o_timers_run), .o_safety_freeze(o_safety_freeze), .o_sensor_10k(o_sensor_10k),
    .o_charger_reset(o_charger_reset), .o_term_disable(o_term_disable),
    .o_charger_enable(o_charger_enable));
`default_nettype wire

// ### pic_host_model.sv
// Behavioural I2C host that reaches the charger register slice
`timescale 1ns/1ps
`default_nettype none
`include "pic_regs.vh"
module pic_host_model #(
    parameter int Q = 8
) (
    input wire logic i_clk, // System clock
    input wire logic i_sda, // Resolved data line
    output logic o_scl, // Clock line, idles high
    output logic o_sda_oe // High pulls data low
);
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic put_bit(input logic b);
        o_sda_oe = !b;
        tick(Q);
        o_scl = 1'b1;
        tick(2 * Q);
        o_scl = 1'b0;
        tick(Q);
    endtask
    task automatic get_bit(output logic b);
        o_sda_oe = 1'b0;
        tick(Q);
        o_scl = 1'b1;
        tick(Q);
        b = i_sda;
        tick(Q);
        o_scl = 1'b0;
        tick(Q);
    endtask
    // Serves as start and repeated start
    task automatic start_cond();
        o_sda_oe = 1'b0;
        tick(Q);
        o_scl = 1'b1;
        tick(Q);
        o_sda_oe = 1'b1;
        tick(Q);
        o_scl = 1'b0;
        tick(Q);
    endtask
    task automatic stop_cond();
        o_sda_oe = 1'b1;
        tick(Q);
        o_scl = 1'b1;
        tick(Q);
        o_sda_oe = 1'b0;
        tick(2 * Q);
    endtask
    task automatic put_byte(input logic [7:0] b, output logic nak);
        for (int i = 7; i >= 0; i--) put_bit(b[i]);
        get_bit(nak);
    endtask
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d,
                             output logic nak);
        logic n1, n2, n3;
        start_cond();
        put_byte({dev, 1'b0}, n1);
        put_byte(ptr, n2);
        put_byte(d, n3);
        stop_cond();
        nak = n1 | n2 | n3;
    endtask
    task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d, output logic nak);
        logic n1, n2, n3;
        start_cond();
        put_byte({`PIC_I2C_ADDR, 1'b0}, n1);
        put_byte(ptr, n2);
        start_cond();
        put_byte({`PIC_I2C_ADDR, 1'b1}, n3);
        for (int i = 7; i >= 0; i--) get_bit(d[i]);
        put_bit(1'b1);
        stop_cond();
        nak = n1 | n2 | n3;
    endtask
endmodule // pic_host_model
`default_nettype wire

// ### pic_i2c_slave.v
// I2C slave front end: address match, register pointer, byte write and read strobes
`timescale 1ns/1ps
`default_nettype none
`include "pic_regs.vh"
module pic_i2c_slave (
    input wire i_clk, // System clock
    input wire i_rst_n, // Synchronous reset, active low
    input wire i_scl, // Synchronised SCL
    input wire i_sda, // Synchronised SDA
    output reg o_sda_oe, // Pull SDA low when high
    output reg [7:0] o_addr, // Register pointer
    output reg o_wr_stb, // Write pulse
    output reg [7:0] o_wr_data, // Write data
    output reg o_rd_stb, // Read pulse, data taken now
    input wire [7:0] i_rd_data // Read data for o_addr
);
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_ACK = 3'h2;
    localparam ST_PTR = 3'h3;
    localparam ST_WDATA = 3'h4;
    localparam ST_RDATA = 3'h5;
    localparam ST_RACK = 3'h6;

    reg [2:0] state;
    reg scl_d;
    reg sda_d;
    reg [3:0] cnt;
    reg [7:0] shift;
    reg [2:0] after_ack;

    wire scl_rise = i_scl & ~scl_d;
    wire scl_fall = ~i_scl & scl_d;
    wire start_c = i_scl & scl_d & sda_d & ~i_sda;
    wire stop_c = i_scl & scl_d & ~sda_d & i_sda;

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            state <= ST_IDLE;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            cnt <= 4'h0;
            shift <= 8'h00;
            after_ack <= ST_IDLE;
            o_sda_oe <= 1'b0;
            o_addr <= 8'h00;
            o_wr_stb <= 1'b0;
            o_wr_data <= 8'h00;
            o_rd_stb <= 1'b0;
        end else begin
            scl_d <= i_scl;
            sda_d <= i_sda;
            o_wr_stb <= 1'b0;
            o_rd_stb <= 1'b0;
            if (start_c) begin
                state <= ST_ADDR;
                cnt <= 4'h0;
                o_sda_oe <= 1'b0;
            end else if (stop_c) begin
                state <= ST_IDLE;
                o_sda_oe <= 1'b0;
            end else begin
                case (state)
                    ST_ADDR, ST_PTR, ST_WDATA: begin
                        if (scl_rise) begin
                            shift <= {shift[6:0], i_sda};
                            cnt <= cnt + 4'h1;
                        end
                        if (scl_fall && cnt == 4'h8) begin
                            cnt <= 4'h0;
                            if (state == ST_ADDR) begin
                                if (shift[7:1] == `PIC_I2C_ADDR) begin
                                    o_sda_oe <= 1'b1;
                                    after_ack <= shift[0] ? ST_RDATA : ST_PTR;
                                    state <= ST_ACK;
                                end else begin
                                    state <= ST_IDLE;
                                end
                            end else begin
                                if (state == ST_PTR) begin
                                    o_addr <= shift;
                                end else begin
                                    o_wr_data <= shift;
                                    o_wr_stb <= 1'b1;
                                end
                                o_sda_oe <= 1'b1;
                                after_ack <= ST_WDATA;
                                state <= ST_ACK;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            state <= after_ack;
                            cnt <= 4'h0;
                            if (after_ack == ST_RDATA) begin
                                // Load the byte and raise the clear-on-read strobe; flags clear on the next cycle
                                shift <= i_rd_data;
                                o_rd_stb <= 1'b1;
                                o_sda_oe <= ~i_rd_data[7];
                            end else begin
                                o_sda_oe <= 1'b0;
                            end
                        end
                    end
                    ST_RDATA: begin
                        if (scl_fall) begin
                            cnt <= cnt + 4'h1;
                            if (cnt == 4'h7) begin
                                o_sda_oe <= 1'b0;
                                state <= ST_RACK;
                            end else begin
                                shift <= {shift[6:0], 1'b0};
                                o_sda_oe <= ~shift[6];
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            // Master NACK ends the read; keep SDA released
                            state <= i_sda ? ST_IDLE : ST_ACK;
                            after_ack <= ST_RDATA;
                            o_addr <= o_addr + 8'h01;
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule // pic_i2c_slave
`default_nettype wire

// ### pic_regs.vh
// Register map, field positions, defaults and timing constants of the charger register slice
`ifndef PIC_REGS_VH
`define PIC_REGS_VH

`define PIC_I2C_ADDR 7'h48
`define PIC_ADDR_INT 8'h02
`define PIC_ADDR_STAT 8'h03
`define PIC_ADDR_CTRL 8'h04

`define PIC_BIT_MASK_SUPPLY 7
`define PIC_BIT_MASK_TOUCH 6
`define PIC_BIT_MASK_PB 5
`define PIC_BIT_EV_TOUCH 3
`define PIC_BIT_EV_PB 2
`define PIC_BIT_EV_APPLIED 1
`define PIC_BIT_EV_REMOVED 0

`define PIC_CTRL_TIMER_HI 7
`define PIC_CTRL_TIMER_LO 6
`define PIC_CTRL_TIMER_EN 5
`define PIC_CTRL_SENSOR 4
`define PIC_CTRL_RESET 3
`define PIC_CTRL_TERM_DIS 2
`define PIC_CTRL_SUSPEND 1
`define PIC_CTRL_ENABLE 0

`define PIC_INT_MASK_RESET 3'h0
`define PIC_INT_MASK_RESET_ALT 3'h4
`define PIC_CTRL_RESET_VAL 8'h31
`define PIC_BYTE_ZERO 8'h00

`define PIC_TMR_4H 2'h0
`define PIC_TMR_5H 2'h1
`define PIC_TMR_6H 2'h2
`define PIC_TMR_8H 2'h3
`define PIC_HOURS_4 4'h4
`define PIC_HOURS_5 4'h5
`define PIC_HOURS_6 4'h6
`define PIC_HOURS_8 4'h8

`endif

// ### pic_sync.v
// Two-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module pic_sync #(
    parameter WIDTH = 1
) (
    input wire i_clk, // System clock
    input wire [WIDTH-1:0] i_async, // Asynchronous inputs
    output reg [WIDTH-1:0] o_sync // Synchronised outputs
);
    reg [WIDTH-1:0] stage1;

    always @(posedge i_clk) begin
        stage1 <= i_async;
        o_sync <= stage1;
    end
endmodule // pic_sync
`default_nettype wire

// ### pmic_irq_charger_regs_tb_top.sv
// Self-checking testbench of the charger register slice
`timescale 1ns/1ps
`default_nettype none
`include "pic_regs.vh"
module pmic_irq_charger_regs_tb_top;
    logic clk, rst_n, uvl, pb, touch, usb, ac, scl, host_oe, sda_oe, sda_o, int_o, int_oe;
    logic timers_run, freeze, sensor, chg_rst, term_dis, chg_en, sda_line;
    logic [3:0] hours;
    logic [7:0] st, ctl_out;
    int n_mismatch = 0;
    int check_count = 0;
    // Pull-up wins unless a party pulls low
    assign sda_line = !(host_oe || sda_oe);
    assign ctl_out = {2'b00, timers_run, sensor, chg_rst, term_dis, freeze, chg_en};
    pic_host_model host_u (.i_clk(clk), .i_sda(sda_line), .o_scl(scl), .o_sda_oe(host_oe));
    pic_charger_regs dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_undervoltage_lockout(uvl),
        .i_scl(scl), .i_sda(sda_line), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_int_n_o(int_o),
        .o_int_n_oe(int_oe), .i_pushbutton_in(pb), .i_pb_active_high(1'b0),
        .i_touch_detect(touch), .i_usb_present(usb), .i_ac_present(ac), .i_thermal_reg(st[7]),
        .i_dynamic_power_path_loop(st[6]), .i_thermal_suspend(st[5]), .i_term_current(st[4]),
        .i_chg_timeout(st[2]), .i_prechg_timeout(st[1]), .i_bat_temp_error(st[0]),
        .o_safety_hours(hours), .o_timers_run(timers_run), .o_safety_freeze(freeze),
        .o_sensor_10k(sensor), .o_charger_reset(chg_rst), .o_term_disable(term_dis),
        .o_charger_enable(chg_en));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic cmp8(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
        logic nak;
        host_u.write_reg(`PIC_I2C_ADDR, ptr, d, nak);
        cmp8("write ack", 8'h00, {7'h00, nak});
    endtask
    task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
        logic [7:0] d;
        logic nak;
        host_u.read_reg(ptr, d, nak);
        cmp8("read ack", 8'h00, {7'h00, nak});
        cmp8("read data", exp, d);
    endtask
    task automatic t_defaults();
        rd(8'h02, 8'h00);
        rd(8'h04, 8'h31);
        cmp8("ctrl outputs", 8'h31, ctl_out);
    endtask
    task automatic t_regs();
        logic [7:0] v [4] = '{8'h2A, 8'h55, 8'hAA, 8'hD5};
        logic [3:0] h [4] = '{`PIC_HOURS_4, `PIC_HOURS_5, `PIC_HOURS_6, `PIC_HOURS_8};
        for (int i = 0; i < 4; i++) begin
            wr(8'h04, v[i]);
            cmp8("ctrl outputs", {2'b00, v[i][5:0]}, ctl_out);
            cmp8("timer hours", {4'h0, h[i]}, {4'h0, hours});
            rd(8'h04, v[i]);
        end
        wr(8'h04, 8'h31);
    endtask
    task automatic t_status();
        st = 8'hFF;
        wr(8'h03, 8'h00);
        rd(8'h03, 8'hF7);
        st = 8'h5A;
        rd(8'h03, 8'h52);
        st = 8'h00;
    endtask
    task automatic t_unlisted();
        logic nak;
        rd(8'h00, 8'h00);
        rd(8'h05, 8'h00);
        host_u.write_reg(7'h49, 8'h04, 8'h00, nak);
        cmp8("foreign address ack", 8'h01, {7'h00, nak});
        rd(8'h04, 8'h31);
    endtask
    task automatic t_events();
        logic [7:0] own;
        logic [7:0] flag;
        for (int k = 0; k < 4; k++) begin
            own = (k == 0) ? 8'h40 : (k == 1) ? 8'h20 : 8'h80;
            flag = 8'h08 >> k;
            wr(8'h02, 8'hE0 & ~own);
            case (k)
                0: begin touch = 1'b1; tick(4); touch = 1'b0; end
                1: begin pb = 1'b0; tick(4); pb = 1'b1; end
                2: usb = 1'b1;
                default: usb = 1'b0;
            endcase
            tick(10);
            cmp8("int masked", 8'h00, {7'h00, int_oe});
            wr(8'h02, 8'hFF);
            cmp8("int unmasked", 8'h01, {7'h00, int_oe});
            rd(8'h02, 8'hE0 | flag);
            cmp8("int after read", 8'h00, {7'h00, int_oe});
            rd(8'h02, 8'hE0);
        end
    endtask
    task automatic t_lockout();
        wr(8'h02, 8'h40);
        touch = 1'b1;
        tick(10);
        cmp8("int before lockout", 8'h01, {7'h00, int_oe});
        wr(8'h04, 8'hCE);
        uvl = 1'b1;
        tick(8);
        uvl = 1'b0;
        tick(4);
        cmp8("int after lockout", 8'h00, {7'h00, int_oe});
        cmp8("ctrl after lockout", 8'h31, ctl_out);
        rd(8'h02, 8'h00);
        rd(8'h04, 8'h31);
        touch = 1'b0;
    endtask
    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Whole sequence needs about 42000 cycles
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        $display("Watchdog expired");
        end_of_test();
    end
    initial begin
        uvl = 1'b0;
        pb = 1'b1;
        touch = 1'b0;
        usb = 1'b0;
        ac = 1'b0;
        st = 8'h00;
        rst_n = 1'b0;
        repeat (20) @(posedge clk);
        #1 rst_n = 1'b1;
        tick(5);
        t_defaults();
        t_regs();
        t_status();
        t_unlisted();
        t_events();
        t_lockout();
        end_of_test();
    end
endmodule // pmic_irq_charger_regs_tb_top
`default_nettype wire
